// [src/shift_logic_alu.sv]
// Shift, rotate, swap and bitwise logic section of an eight-bit core.
// Holds the working register and the four status flags. Memory and I/O
// share one byte port with a one-cycle read latency on the core clock.
`timescale 1ns/1ps
module shift_logic_alu
  import shift_logic_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              op_valid_i,
  input  wire logic [3:0]        op_code_i,
  input  wire logic [1:0]        op_mode_i,
  input  wire logic [DATA_W-1:0] op_imm_i,
  input  wire logic [ADDR_W-1:0] op_addr_i,
  input  wire logic              work_load_i,
  input  wire logic [DATA_W-1:0] work_load_data_i,
  input  wire logic              flags_load_i,
  input  wire logic [3:0]        flags_load_data_i,
  input  wire logic [DATA_W-1:0] mem_rdata_i,
  output logic                   ready_o,
  output logic                   done_o,
  output logic [DATA_W-1:0]      working_register_o,
  output logic                   zero_flag_o,
  output logic                   shift_out_flag_o,
  output logic                   half_carry_flag_o,
  output logic                   signed_range_error_flag_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   mem_io_o,
  output logic                   mem_rd_o,
  output logic                   mem_wr_o,
  output logic [DATA_W-1:0]      mem_wdata_o
);

  state_type         state;
  logic [3:0]        op_q;
  logic [1:0]        mode_q;
  logic [DATA_W-1:0] alu_result;
  logic              alu_carry;
  logic              upd_carry;
  logic              upd_zero;

  // Operation fields come straight from the decoder while idle
  wire              take      = (state == ST_IDLE) && op_valid_i;
  wire              at_wait   = (state == ST_WAIT);
  wire [3:0]        cur_op    = at_wait ? op_q : op_code_i;
  wire [1:0]        cur_mode  = at_wait ? mode_q : op_mode_i;
  wire              reg_only  = (op_mode_i == MODE_REG);
  wire [DATA_W-1:0] subj      = at_wait ? mem_rdata_i : working_register_o;
  wire [DATA_W-1:0] second    = at_wait ? mem_rdata_i : op_imm_i;
  wire              commit    = (take && reg_only) || at_wait;
  wire              to_work   = commit &&
                                (cur_mode == MODE_REG || cur_mode == MODE_MEM_REG);
  wire              write_back = at_wait &&
                                (mode_q == MODE_MEM_MEM || mode_q == MODE_IO_IO);
  // I/O write-back keeps every flag as it was
  wire              flags_en  = commit && (cur_mode != MODE_IO_IO);
  wire              res_zero  = (alu_result == WORK_RST);

  // Result and flag selection per operation
  always_comb begin
    alu_result = subj;
    alu_carry  = shift_out_flag_o;
    upd_carry  = 1'b0;
    upd_zero   = 1'b0;
    case (cur_op)
      OP_SHR: begin
        alu_result = {1'b0, subj[MSB:1]};
        alu_carry  = subj[LSB];
        upd_carry  = 1'b1;
      end
      OP_RRC: begin
        alu_result = {shift_out_flag_o, subj[MSB:1]};
        alu_carry  = subj[LSB];
        upd_carry  = 1'b1;
      end
      OP_SHL: begin
        alu_result = {subj[MSB-1:0], 1'b0};
        alu_carry  = subj[MSB];
        upd_carry  = 1'b1;
      end
      OP_RLC: begin
        alu_result = {subj[MSB-1:0], shift_out_flag_o};
        alu_carry  = subj[MSB];
        upd_carry  = 1'b1;
      end
      OP_SWAP: begin
        alu_result = {subj[3:0], subj[MSB:4]};
      end
      OP_AND: begin
        alu_result = working_register_o & second;
        upd_zero   = 1'b1;
      end
      OP_OR: begin
        alu_result = working_register_o | second;
        upd_zero   = 1'b1;
      end
      OP_XOR: begin
        alu_result = working_register_o ^ second;
        upd_zero   = 1'b1;
      end
      OP_NOT: begin
        alu_result = ~subj;
        upd_zero   = 1'b1;
      end
      OP_NEG: begin
        alu_result = DATA_W'(~subj + 8'h01);
        upd_zero   = 1'b1;
      end
      default: begin
        alu_result = subj;
      end
    endcase
  end

  // sequence with no gap
  // A memory request holds the datapath until its write has gone out, so no
  // other operation can slip between the read and the write of one byte.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE:  state <= (take && !reg_only) ? ST_READ : ST_IDLE;
        ST_READ:  state <= ST_WAIT;
        ST_WAIT:  state <= write_back ? ST_WRITE : ST_IDLE;
        ST_WRITE: state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // Latched operation for the multi-cycle path
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      op_q       <= OP_SHR;
      mode_q     <= MODE_REG;
      mem_addr_o <= ADDR_RST;
      mem_io_o   <= 1'b0;
    end else if (take && !reg_only) begin
      op_q       <= op_code_i;
      mode_q     <= op_mode_i;
      mem_addr_o <= op_addr_i;
      mem_io_o   <= (op_mode_i == MODE_IO_IO);
    end
  end

  // Port strobes; the address stays put until the next request
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_wdata_o <= WORK_RST;
      done_o      <= 1'b0;
      ready_o     <= 1'b0;
    end else begin
      mem_rd_o <= take && !reg_only;
      mem_wr_o <= write_back;
      done_o   <= commit;
      ready_o  <= (state == ST_IDLE) ? !(take && !reg_only) : (state == ST_WRITE) ||
                  (at_wait && !write_back);
      if (write_back) begin
        mem_wdata_o <= alu_result;
      end
    end
  end

  // Working register: an operation result wins over a direct load
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      working_register_o <= WORK_RST;
    end else if (to_work) begin
      working_register_o <= alu_result;
    end else if (work_load_i) begin
      working_register_o <= work_load_data_i;
    end
  end

  // flag gating
  // Half-carry and range-error flags change only by a direct load, since
  // no operation of this section produces them.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      zero_flag_o               <= FLAG_RST;
      shift_out_flag_o          <= FLAG_RST;
      half_carry_flag_o         <= FLAG_RST;
      signed_range_error_flag_o <= FLAG_RST;
    end else if (flags_en) begin
      if (upd_zero) begin
        zero_flag_o <= res_zero;
      end
      if (upd_carry) begin
        shift_out_flag_o <= alu_carry;
      end
    end else if (flags_load_i) begin
      {zero_flag_o, shift_out_flag_o, half_carry_flag_o,
       signed_range_error_flag_o} <= flags_load_data_i;
    end
  end

  // Checks
  wire take_reg = take && reg_only;
  wire take_mem = take && !reg_only;

  sequence rmw_seq;
    mem_rd_o && !mem_wr_o ##1 !mem_rd_o && !mem_wr_o ##1 mem_wr_o && !mem_rd_o;
  endsequence

  sequence read_only_seq;
    mem_rd_o ##1 !mem_rd_o && !mem_wr_o ##1 !mem_wr_o;
  endsequence

  a_shr_work: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_reg && op_code_i == OP_SHR |=> working_register_o ==
      {1'b0, $past(working_register_o[MSB:1])} &&
      shift_out_flag_o == $past(working_register_o[LSB]))
    else $error("right shift of working register wrong");

  a_rrc_work: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_reg && op_code_i == OP_RRC |=> working_register_o[MSB] ==
      $past(shift_out_flag_o) && shift_out_flag_o == $past(working_register_o[LSB]))
    else $error("right rotate of working register wrong");

  a_shl_work: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_reg && op_code_i == OP_SHL |=> working_register_o ==
      {$past(working_register_o[MSB-1:0]), 1'b0} &&
      shift_out_flag_o == $past(working_register_o[MSB]))
    else $error("left shift of working register wrong");

  a_rlc_work: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_reg && op_code_i == OP_RLC |=> working_register_o[LSB] ==
      $past(shift_out_flag_o) && shift_out_flag_o == $past(working_register_o[MSB]))
    else $error("left rotate of working register wrong");

  a_shr_mem: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    at_wait && op_q == OP_SHR && mode_q == MODE_MEM_MEM |=> mem_wr_o &&
      mem_wdata_o == {1'b0, $past(mem_rdata_i[MSB:1])} &&
      shift_out_flag_o == $past(mem_rdata_i[LSB]))
    else $error("memory right shift wrong");

  a_rlc_mem: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    at_wait && op_q == OP_RLC && mode_q == MODE_MEM_MEM |=> mem_wr_o &&
      mem_wdata_o == {$past(mem_rdata_i[MSB-1:0]), $past(shift_out_flag_o)})
    else $error("memory left rotate wrong");

  a_shift_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    commit && cur_op <= OP_RLC && !flags_load_i |=> $stable(zero_flag_o) &&
      $stable(half_carry_flag_o) && $stable(signed_range_error_flag_o))
    else $error("shift touched a flag other than shift-out");

  a_swap_work: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_reg && op_code_i == OP_SWAP && !flags_load_i |=> working_register_o ==
      {$past(working_register_o[3:0]), $past(working_register_o[MSB:4])} &&
      $stable({zero_flag_o, shift_out_flag_o}))
    else $error("nibble swap wrong");

  a_io_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    at_wait && mode_q == MODE_IO_IO && !flags_load_i |=> mem_io_o &&
      $stable({zero_flag_o, shift_out_flag_o, half_carry_flag_o,
               signed_range_error_flag_o}))
    else $error("I/O write-back changed a flag");

  a_zero_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_reg && op_code_i >= OP_AND && op_code_i <= OP_NEG |=>
      zero_flag_o == (working_register_o == WORK_RST))
    else $error("zero flag disagrees with result");

  a_neg_work: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_reg && op_code_i == OP_NEG |=>
      DATA_W'(working_register_o + $past(working_register_o)) == WORK_RST)
    else $error("negate of working register wrong");

  a_rmw_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_mem && (op_mode_i == MODE_MEM_MEM || op_mode_i == MODE_IO_IO) |=>
      rmw_seq ##1 ready_o)
    else $error("read-modify-write sequence broken");

  a_read_only: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_mem && op_mode_i == MODE_MEM_REG |=> read_only_seq)
    else $error("memory-to-register operation wrote memory");

endmodule : shift_logic_alu

// [src/shift_logic_pkg.sv]
// Constants, operation codes and state type for the shift and logic datapath.
// Assumes one core clock, a synchronous active-high reset and a decoder
// that presents one operation at a time while the datapath is ready.
//
// Functional notes
// - Right shift of working register: zero into bit 7, bit 0 to shift-out flag.
// - Right rotate of working register: old flag into bit 7, bit 0 to flag.
// - Right shift of memory byte writes back, zero into bit 7, bit 0 to flag.
// - Right rotate of memory byte writes back old flag in bit 7, bit 0 to flag.
// - Left shift of working register: zero into bit 0, bit 7 to shift-out flag.
// - Left rotate of working register: old flag into bit 0, bit 7 to flag.
// - Left shift of memory byte writes back, zero into bit 0, bit 7 to flag.
// - Left rotate of memory byte writes back old flag in bit 0, bit 7 to flag.
// - Shifts and rotates change only the shift-out flag.
// - Nibble swap of working register exchanges halves, no flag changes.
// - AND with immediate or memory into working register, or into memory.
// - OR with immediate or memory into working register, or into memory.
// - XOR with immediate or memory into working register, or into memory.
// - XOR with an I/O register writes that register back, no flag changes.
// - Logic, complement and negate change only the zero flag.
// - One's complement inverts working register or a memory byte.
// - Two's complement negates working register or a memory byte.
package shift_logic_pkg;

  localparam int          DATA_W   = 8;
  localparam int          ADDR_W   = 8;
  localparam int          MSB      = 7;
  localparam int          LSB      = 0;

  // Operation codes
  localparam logic [3:0]  OP_SHR   = 4'h0;
  localparam logic [3:0]  OP_RRC   = 4'h1;
  localparam logic [3:0]  OP_SHL   = 4'h2;
  localparam logic [3:0]  OP_RLC   = 4'h3;
  localparam logic [3:0]  OP_SWAP  = 4'h4;
  localparam logic [3:0]  OP_AND   = 4'h5;
  localparam logic [3:0]  OP_OR    = 4'h6;
  localparam logic [3:0]  OP_XOR   = 4'h7;
  localparam logic [3:0]  OP_NOT   = 4'h8;
  localparam logic [3:0]  OP_NEG   = 4'h9;

  // Operand and destination modes
  localparam logic [1:0]  MODE_REG     = 2'h0;
  localparam logic [1:0]  MODE_MEM_REG = 2'h1;
  localparam logic [1:0]  MODE_MEM_MEM = 2'h2;
  localparam logic [1:0]  MODE_IO_IO   = 2'h3;

  // Reset values
  localparam logic [7:0]  WORK_RST = 8'h00;
  localparam logic [7:0]  ADDR_RST = 8'h00;
  localparam logic        FLAG_RST = 1'b0;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WAIT, ST_WRITE} state_type;

endpackage : shift_logic_pkg

// [tb/data_memory_model.sv]
// Behavioural data memory and I/O register space on the datapath's byte port.
// Assumes one shared clock and read data expected one cycle after the strobe.
`timescale 1ns/1ps
module data_memory_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] mem_addr_i,
  input  wire logic       mem_io_i,
  input  wire logic       mem_rd_i,
  input  wire logic       mem_wr_i,
  input  wire logic [7:0] mem_wdata_i,
  output logic      [7:0] mem_rdata_o
);
  logic [7:0] mem [256];
  logic [7:0] io  [256];
  logic [7:0] rd_q = 8'h00;

  assign mem_rdata_o = rd_q;

  // Read data holds one cycle only; otherwise the bus shows the inverse of
  // its last value, so a late sample cannot pass by luck
  always @(posedge clk_i) begin
    if (mem_rd_i)
      rd_q <= mem_io_i ? io[mem_addr_i] : mem[mem_addr_i];
    else
      rd_q <= ~rd_q;
  end

  // Write strobe lands in the space that the address flag selects
  always @(posedge clk_i) begin
    if (mem_wr_i && mem_io_i)
      io[mem_addr_i] <= mem_wdata_i;
    if (mem_wr_i && !mem_io_i)
      mem[mem_addr_i] <= mem_wdata_i;
  end
endmodule : data_memory_model

// [tb/shift_logic_alu_tb.sv]
// Self-checking bench for the shift and logic datapath with a memory model.
// Assumes the package encodings and the hand-over timing of the operation port.
`timescale 1ns/1ps
module shift_logic_alu_tb;
  import shift_logic_pkg::*;
  logic       clk_i, sys_rst_i, op_valid_i, work_load_i, flags_load_i;
  logic [3:0] op_code_i, flags_load_data_i;
  logic [1:0] op_mode_i;
  logic [7:0] op_imm_i, op_addr_i, work_load_data_i;
  wire  logic [7:0] mem_rdata_i, working_register_o, mem_addr_o, mem_wdata_o;
  wire  logic ready_o, done_o, zero_flag_o, shift_out_flag_o, half_carry_flag_o;
  wire  logic signed_range_error_flag_o, mem_io_o, mem_rd_o, mem_wr_o;
  int         n_fail, compares;

  shift_logic_alu dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .op_mode_i(op_mode_i), .op_imm_i(op_imm_i), .op_addr_i(op_addr_i),
    .work_load_i(work_load_i), .work_load_data_i(work_load_data_i),
    .flags_load_i(flags_load_i), .flags_load_data_i(flags_load_data_i),
    .mem_rdata_i(mem_rdata_i), .ready_o(ready_o), .done_o(done_o),
    .working_register_o(working_register_o), .zero_flag_o(zero_flag_o),
    .shift_out_flag_o(shift_out_flag_o), .half_carry_flag_o(half_carry_flag_o),
    .signed_range_error_flag_o(signed_range_error_flag_o), .mem_addr_o(mem_addr_o),
    .mem_io_o(mem_io_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o));

  data_memory_model mem_u (.clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_io_i(mem_io_o),
    .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o),
    .mem_rdata_o(mem_rdata_i));

  // 250 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: flags got %h expected %h", $time, got, exp);
    end
  endtask : chk_flags

  // Preload working register, flags and operand byte, run one operation,
  // then compare latency, register, flags and both memory spaces
  task automatic run_case(input logic [3:0] code, input logic [1:0] mode,
                          input logic [7:0] w, input logic [3:0] f,
                          input logic [7:0] imm, input logic [7:0] a, input logic [7:0] m);
    logic [7:0] src, opd, r;
    logic [3:0] nf;
    int         k;
    src = (mode == MODE_REG) ? w : m;
    opd = (mode == MODE_REG) ? imm : m;
    nf  = f;
    r   = src;
    case (code)
      OP_SHR:  {r, nf[2]} = {1'b0, src};
      OP_RRC:  {r, nf[2]} = {f[2], src};
      OP_SHL:  {nf[2], r} = {src, 1'b0};
      OP_RLC:  {nf[2], r} = {src, f[2]};
      OP_SWAP: r = {src[3:0], src[7:4]};
      OP_AND:  r = w & opd;
      OP_OR:   r = w | opd;
      OP_XOR:  r = w ^ opd;
      OP_NOT:  r = ~src;
      OP_NEG:  r = 8'h00 - src;
      default: r = src;
    endcase
    if (code >= OP_AND && code <= OP_NEG)
      nf[3] = (r == 8'h00);
    if (mode == MODE_IO_IO)
      nf = f;
    @(negedge clk_i);
    work_load_i = 1'b1;
    work_load_data_i = w;
    flags_load_i = 1'b1;
    flags_load_data_i = f;
    mem_u.mem[a] = m;
    mem_u.io[a] = m;
    @(negedge clk_i);
    work_load_i = 1'b0;
    flags_load_i = 1'b0;
    k = 0;
    while (ready_o !== 1'b1 && k < 8) begin
      @(negedge clk_i);
      k++;
    end
    {op_valid_i, op_code_i, op_mode_i, op_imm_i, op_addr_i} = {1'b1, code, mode, imm, a};
    @(negedge clk_i);
    op_valid_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 8) begin
      @(negedge clk_i);
      k++;
    end
    chk_byte(8'(k), (mode == MODE_REG) ? 8'h00 : 8'h02);
    chk_byte(working_register_o, (code > OP_NEG || mode > MODE_MEM_REG) ? w : r);
    chk_flags({zero_flag_o, shift_out_flag_o, half_carry_flag_o,
               signed_range_error_flag_o}, nf);
    // The write strobe stands with done, so the byte lands one edge later
    @(negedge clk_i);
    chk_byte(mem_u.mem[a], (mode == MODE_MEM_MEM && code <= OP_NEG) ? r : m);
    chk_byte(mem_u.io[a], (mode == MODE_IO_IO && code <= OP_NEG) ? r : m);
  endtask : run_case

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // Main sequence: reset, codes 0 to 10 in register mode, the same less swap and 10 in both memory modes, then edge cases
  initial begin
    {sys_rst_i, op_valid_i, work_load_i, flags_load_i} = 4'b1000;
    {op_code_i, op_mode_i, op_imm_i, op_addr_i} = '0;
    {work_load_data_i, flags_load_data_i} = '0;
    repeat (3) @(negedge clk_i);
    chk_byte(working_register_o, WORK_RST);
    sys_rst_i = 1'b0;
    for (int c = 0; c < 2; c++) begin
      for (int md = 0; md < 3; md++) begin
        for (int code = 0; code < 11; code++) begin
          if ((code == 4 || code == 10) && md != 0)
            continue;
          run_case(4'(code), 2'(md), c ? 8'h81 : 8'h5A, c ? 4'hD : 4'hA, 8'h3C,
                   8'(8'h40 + code), c ? 8'h18 : 8'hA5);
        end
      end
    end
    $display("test shift and logic table done");
    run_case(OP_XOR, MODE_IO_IO, 8'hF0, 4'h5, 8'h00, 8'h12, 8'h3C);
    run_case(OP_AND, MODE_REG, 8'h5A, 4'h0, 8'h00, 8'h00, 8'h00);
    run_case(OP_NEG, MODE_MEM_MEM, 8'h11, 4'h2, 8'h00, 8'h20, 8'h00);
    run_case(OP_NOT, MODE_MEM_REG, 8'h00, 4'h0, 8'h00, 8'h21, 8'hFF);
    run_case(OP_NEG, MODE_MEM_MEM, 8'h00, 4'h8, 8'h00, 8'h22, 8'h38);
    $display("test zero flag and io done");
    test_done();
  end

  // Whole run needs about 340 cycles; far beyond that means a hang
  initial begin
    #20000;
    n_fail++;
    $display("watchdog expired at %0t", $time);
    test_done();
  end
endmodule : shift_logic_alu_tb
